// ===== hw/sfs_front.sv
// Serial flash front end: link shifter on the serial clock, framing and decode on mclk
`timescale 1ns/10ps
module sfs_front #(
	parameter logic [7:0] OP_PROG   = 8'h01,
	parameter logic [7:0] OP_SECTOR = 8'h02,
	parameter logic [7:0] OP_BULK   = 8'h03,
	parameter logic [7:0] OP_STATUS = 8'h04
) (
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire logic                 sck,
	input  wire logic                 cs_n,
	input  wire logic                 mosi,
	input  wire logic                 hold_n,
	input  wire logic                 wp_n,
	input  wire logic                 high_program_voltage_level,
	input  wire logic                 busy,
	input  wire logic [7:0]           old_byte,
	input  wire logic                 tx_load,
	input  wire logic [7:0]           tx_data,
	output logic                      miso_o,
	output logic                      miso_oe_n,
	output logic                      active,
	output logic                      standby,
	output logic                      protect_lock,
	output logic                      fast_mode,
	output sfs_pkg::sfs_rx_t          rx,
	output sfs_pkg::sfs_prog_t        prog,
	output sfs_pkg::sfs_commit_t      commit,
	output logic                      discard
);
	sfs_pkg::sfs_link_t link_q;
	sfs_pkg::sfs_link_t link_d;
	sfs_pkg::sfs_core_t core_q;
	sfs_pkg::sfs_core_t core_d;
	logic               link_rst_n;
	logic               rx_tgl_q;
	logic [7:0]         txsh_q;
	logic               miso_q;
	logic [4:0]         async_in;
	logic               byte_ev;
	logic               cs_rise;
	logic               cs_fall;
	logic               wr_kind;
	sfs_pkg::sfs_cmd_t  kind;

	// Link domain is cleared while deselected
	assign link_rst_n = rstn & ~cs_n;

	always_comb begin
		link_d = link_q;
		if (hold_n) begin
			link_d.shreg  = {link_q.shreg[6:0], mosi};
			link_d.bitcnt = link_q.bitcnt + 3'h1;
			if (link_q.bitcnt == sfs_pkg::BIT_LAST) begin
				link_d.rx_byte = {link_q.shreg[6:0], mosi};
				link_d.rx_tgl  = ~link_q.rx_tgl;
			end
		end
	end

	always_ff @(posedge sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_q <= '0;
		end else begin
			link_q <= link_d;
		end
	end

	// Byte toggle survives deselect so an odd byte count gives no false byte event
	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn) begin
			rx_tgl_q <= 1'b0;
		end else if (hold_n && link_q.bitcnt == sfs_pkg::BIT_LAST) begin
			rx_tgl_q <= ~rx_tgl_q;
		end
	end

	// Output shifter on the falling edge; tx byte is held stable by the core
	always_ff @(negedge sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			txsh_q <= '0;
			miso_q <= 1'b0;
		end else if (hold_n) begin
			if (link_q.bitcnt == 3'h0) begin
				miso_q <= core_q.tx[7];
				txsh_q <= {core_q.tx[6:0], 1'b0};
			end else begin
				miso_q <= txsh_q[7];
				txsh_q <= {txsh_q[6:0], 1'b0};
			end
		end
	end

	assign miso_o    = miso_q;
	assign miso_oe_n = cs_n | ~hold_n;

	assign async_in = {link_q.bitcnt != 3'h0, rx_tgl_q, high_program_voltage_level, wp_n, cs_n};

	assign cs_rise = core_q.filt[sfs_pkg::S_CS] & ~core_q.cs_prev;
	assign cs_fall = ~core_q.filt[sfs_pkg::S_CS] & core_q.cs_prev;
	assign byte_ev = core_q.filt[sfs_pkg::S_TGL] != core_q.tgl_seen;

	always_comb begin
		kind = sfs_pkg::CMD_NONE;
		if (core_q.opcode == OP_PROG) begin
			kind = sfs_pkg::CMD_PROG;
		end else if (core_q.opcode == OP_SECTOR) begin
			kind = sfs_pkg::CMD_SECTOR;
		end else if (core_q.opcode == OP_BULK) begin
			kind = sfs_pkg::CMD_BULK;
		end else if (core_q.opcode == OP_STATUS) begin
			kind = sfs_pkg::CMD_STATUS;
		end
	end
	assign wr_kind = kind != sfs_pkg::CMD_NONE;

	always_comb begin
		core_d.cs_prev  = core_q.filt[sfs_pkg::S_CS];
		core_d.tgl_seen = core_q.filt[sfs_pkg::S_TGL];
		core_d.part_q   = core_q.filt[sfs_pkg::S_CS] ? core_q.part_q : core_q.filt[sfs_pkg::S_PART];
		core_d.frame    = core_q.frame;
		core_d.idx      = core_q.idx;
		core_d.opcode   = core_q.opcode;
		core_d.addr     = core_q.addr;
		core_d.count    = core_q.count;
		core_d.tx       = tx_load ? tx_data : core_q.tx;
		core_d.rx       = '0;
		core_d.prog     = '0;
		core_d.commit   = '0;
		core_d.discard  = 1'b0;
		// Three-stage synchronisers, a change counts once stages two and three agree
		core_d.s1       = async_in;
		core_d.s2       = core_q.s1;
		core_d.s3       = core_q.s2;
		for (int i = 0; i < sfs_pkg::SYNC_N; i++) begin
			core_d.filt[i] = (core_q.s2[i] == core_q.s3[i]) ? core_q.s3[i] : core_q.filt[i];
		end
		case (core_q.frame)
			sfs_pkg::FR_IDLE: begin
				if (cs_fall) begin
					core_d.frame = sfs_pkg::FR_SEL;
				end
			end
			sfs_pkg::FR_READY: begin
				if (cs_fall) begin
					core_d.frame = sfs_pkg::FR_SEL;
				end
			end
			sfs_pkg::FR_SEL: begin
				if (byte_ev) begin
					core_d.rx.valid = 1'b1;
					core_d.rx.first = core_q.idx == 9'h000;
					core_d.rx.data  = link_q.rx_byte;
					if (core_q.idx != sfs_pkg::IDX_MAX) begin
						core_d.idx = core_q.idx + 9'h001;
					end
					if (core_q.idx == 9'h000) begin
						core_d.opcode = link_q.rx_byte;
					end else if (core_q.idx < sfs_pkg::IDX_DATA) begin
						core_d.addr = {core_q.addr[15:0], link_q.rx_byte};
					end else if (kind == sfs_pkg::CMD_PROG && core_q.count < sfs_pkg::PAGE_BYTES) begin
						core_d.count        = core_q.count + 9'h001;
						core_d.prog.valid   = 1'b1;
						core_d.prog.sector  = core_q.addr[sfs_pkg::SECTOR_LSB +: sfs_pkg::SECTOR_W];
						core_d.prog.page    = core_q.addr[sfs_pkg::PAGE_LSB +: sfs_pkg::PAGE_W];
						core_d.prog.col     = core_q.addr[sfs_pkg::COL_LSB +: sfs_pkg::COL_W] + core_q.count[7:0];
						core_d.prog.data    = old_byte & link_q.rx_byte;
					end
				end
				if (cs_rise) begin
					core_d.frame  = sfs_pkg::FR_READY;
					core_d.idx    = '0;
					core_d.opcode = '0;
					core_d.count  = '0;
					if (wr_kind) begin
						if (core_q.part_q || (kind == sfs_pkg::CMD_PROG && core_q.count == 9'h000)) begin
							core_d.discard = 1'b1;
						end else begin
							core_d.commit.valid  = 1'b1;
							core_d.commit.kind   = kind;
							core_d.commit.sector = core_q.addr[sfs_pkg::SECTOR_LSB +: sfs_pkg::SECTOR_W];
							core_d.commit.page   = core_q.addr[sfs_pkg::PAGE_LSB +: sfs_pkg::PAGE_W];
							core_d.commit.col    = core_q.addr[sfs_pkg::COL_LSB +: sfs_pkg::COL_W];
							core_d.commit.count  = core_q.count;
							core_d.commit.fast   = core_q.filt[sfs_pkg::S_HV];
						end
					end
				end
			end
			default: begin
				core_d.frame = sfs_pkg::FR_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			core_q <= '0;
		end else begin
			core_q <= core_d;
		end
	end

	assign rx           = core_q.rx;
	assign prog         = core_q.prog;
	assign commit       = core_q.commit;
	assign discard      = core_q.discard;
	assign active       = ~core_q.filt[sfs_pkg::S_CS] | busy;
	assign standby      = ~active;
	assign fast_mode    = core_q.filt[sfs_pkg::S_HV];
	assign protect_lock = ~core_q.filt[sfs_pkg::S_WP] & ~core_q.filt[sfs_pkg::S_HV];

	float_out_a: assert property (@(posedge mclk) disable iff (!rstn)
		(cs_n || !hold_n) |-> miso_oe_n)
		else $error("data output driven while deselected or held");
	standby_cond_a: assert property (@(posedge mclk) disable iff (!rstn)
		standby |-> (!busy && core_q.filt[sfs_pkg::S_CS]))
		else $error("standby while selected or busy");
	active_sel_a: assert property (@(posedge mclk) disable iff (!rstn)
		!core_q.filt[sfs_pkg::S_CS] |-> active)
		else $error("selected device not active");
	arm_first_a: assert property (@(posedge mclk) disable iff (!rstn)
		(core_q.frame == sfs_pkg::FR_IDLE) |=> !rx.valid && !commit.valid)
		else $error("traffic taken before first select edge");
	whole_byte_a: assert property (@(posedge mclk) disable iff (!rstn)
		commit.valid |-> !$past(core_q.part_q) && $past(cs_rise))
		else $error("write command committed after partial byte");
	prog_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
		prog.valid |-> ((prog.data & ~$past(old_byte)) == 8'h00))
		else $error("programming set a bit");
	prog_count_a: assert property (@(posedge mclk) disable iff (!rstn)
		(commit.valid && commit.kind == sfs_pkg::CMD_PROG) |-> (commit.count != 9'h000 && commit.count <= sfs_pkg::PAGE_BYTES))
		else $error("page program byte count out of range");
	lock_fast_a: assert property (@(posedge mclk) disable iff (!rstn)
		fast_mode |-> !protect_lock)
		else $error("lock and fast mode together");
	bit_step_a: assert property (@(posedge sck) disable iff (!link_rst_n)
		hold_n |=> link_q.bitcnt == $past(link_q.bitcnt) + 3'h1)
		else $error("bit counter did not advance");
	hold_freeze_a: assert property (@(posedge sck) disable iff (!link_rst_n)
		!hold_n |=> $stable(link_q))
		else $error("link state changed during hold");

	prog_commit_c: cover property (@(posedge mclk) disable iff (!rstn)
		commit.valid && commit.kind == sfs_pkg::CMD_PROG);
	discard_c: cover property (@(posedge mclk) disable iff (!rstn) discard);
	hold_mid_c: cover property (@(posedge sck) disable iff (!link_rst_n)
		!hold_n && link_q.bitcnt != 3'h0);
	sector_commit_c: cover property (@(posedge mclk) disable iff (!rstn)
		commit.valid && commit.kind == sfs_pkg::CMD_SECTOR);
	fast_commit_c: cover property (@(posedge mclk) disable iff (!rstn)
		commit.valid && commit.fast);

	oe_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
		(!cs_n && hold_n) |-> !miso_oe_n)
		else $error("data output floating while selected");
	standby_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
		(!busy && core_q.filt[sfs_pkg::S_CS]) |-> standby)
		else $error("deselected idle device not in standby");
	sel_frame_a: assert property (@(posedge mclk) disable iff (!rstn)
		cs_fall |=> core_q.frame == sfs_pkg::FR_SEL)
		else $error("select edge did not open a frame");
	commit_fast_a: assert property (@(posedge mclk) disable iff (!rstn)
		commit.valid |-> commit.fast == $past(fast_mode))
		else $error("fast flag of commit wrong");
	count_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
		core_q.count <= sfs_pkg::PAGE_BYTES)
		else $error("program byte count above page size");
	prog_rx_a: assert property (@(posedge mclk) disable iff (!rstn)
		prog.valid |-> rx.valid && prog.data == (rx.data & $past(old_byte)))
		else $error("programmed byte not old AND new");
	one_outcome_a: assert property (@(posedge mclk) disable iff (!rstn)
		discard |-> !commit.valid)
		else $error("command both committed and discarded");
	link_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
		cs_n |-> (link_q.bitcnt == 3'h0 && link_q.shreg == 8'h00))
		else $error("link state kept while deselected");
endmodule

// ===== hw/sfs_pkg.sv
// Package of constants and carrier types for the serial flash front end
package sfs_pkg;
	localparam int          BYTE_W       = 8;
	localparam int          ADDR_BYTES   = 3;
	localparam int          SYNC_N       = 5;
	localparam int          SECTOR_W     = 7;
	localparam int          PAGE_W       = 8;
	localparam int          COL_W        = 8;
	localparam int          SECTOR_LSB   = 16;
	localparam int          PAGE_LSB     = 8;
	localparam int          COL_LSB      = 0;
	localparam int          CNT_W        = 9;
	localparam logic [8:0]  PAGE_BYTES   = 9'h0100;
	localparam logic [8:0]  IDX_MAX      = 9'h01ff;
	localparam logic [8:0]  IDX_DATA     = 9'h0004;
	localparam logic [2:0]  BIT_LAST     = 3'h7;
	localparam logic [7:0]  ERASED_BYTE  = 8'hff;
	localparam logic [4:0]  SYNC_RST     = 5'h00;
	localparam int          S_CS         = 0;
	localparam int          S_WP         = 1;
	localparam int          S_HV         = 2;
	localparam int          S_TGL        = 3;
	localparam int          S_PART       = 4;

	typedef enum logic [1:0] {
		FR_IDLE  = 2'b00,
		FR_READY = 2'b01,
		FR_SEL   = 2'b10
	} sfs_frame_t;

	typedef enum logic [2:0] {
		CMD_NONE   = 3'b000,
		CMD_PROG   = 3'b001,
		CMD_SECTOR = 3'b010,
		CMD_BULK   = 3'b011,
		CMD_STATUS = 3'b100
	} sfs_cmd_t;

	typedef struct packed {
		logic [2:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] rx_byte;
		logic       rx_tgl;
	} sfs_link_t;

	typedef struct packed {
		logic       valid;
		sfs_cmd_t   kind;
		logic [6:0] sector;
		logic [7:0] page;
		logic [7:0] col;
		logic [8:0] count;
		logic       fast;
	} sfs_commit_t;

	typedef struct packed {
		logic       valid;
		logic       first;
		logic [7:0] data;
	} sfs_rx_t;

	typedef struct packed {
		logic       valid;
		logic [6:0] sector;
		logic [7:0] page;
		logic [7:0] col;
		logic [7:0] data;
	} sfs_prog_t;

	typedef struct packed {
		logic [4:0]  s1;
		logic [4:0]  s2;
		logic [4:0]  s3;
		logic [4:0]  filt;
		logic        cs_prev;
		logic        tgl_seen;
		logic        part_q;
		sfs_frame_t  frame;
		logic [8:0]  idx;
		logic [7:0]  opcode;
		logic [23:0] addr;
		logic [8:0]  count;
		logic [7:0]  tx;
		sfs_rx_t     rx;
		sfs_prog_t   prog;
		sfs_commit_t commit;
		logic        discard;
	} sfs_core_t;
endpackage

// ===== verif/sfs_master.sv
// SPI bus master model that drives the flash front end
`timescale 1ns/10ps
module sfs_master #(
	parameter bit START_SEL = 1'b0
) (
	output logic     sck,
	output logic     cs_n,
	output logic     mosi,
	output logic     hold_n,
	input  wire logic mode
);
	initial begin
		cs_n = START_SEL ? 1'b0 : 1'b1;
		hold_n = 1'b1;
		mosi = 1'b0;
		sck = 1'b0;
	end
	task automatic sel();
		sck = mode;
		#41 cs_n = 1'b0;
		#41;
	endtask
	task automatic desel();
		#51 cs_n = 1'b1;
		mosi = ~mosi;
		sck = mode;
		#61;
	endtask
	task automatic xfer(input logic [7:0] b, input int n, input int hb);
		for (int i = 7; i > 7 - n; i--) begin
			sck = 1'b0;
			mosi = b[i];
			if (i == hb) begin
				#8 hold_n = 1'b0;
				for (int j = 0; j < 2; j++) begin
					#16 sck = ~sck;
					mosi = ~mosi;
				end
				#16 hold_n = 1'b1;
				mosi = b[i];
			end
			#16 sck = 1'b1;
			#16;
		end
	endtask
endmodule

// ===== verif/sfs_front_tb.sv
// Testbench for the serial flash front end
`timescale 1ns/10ps
module sfs_front_tb;
	logic                 mclk = 1'b0;
	logic                 rstn = 1'b0;
	logic                 mode = 1'b0;
	logic                 wp_n = 1'b1;
	logic                 hv = 1'b0;
	logic                 busy = 1'b0;
	logic [7:0]           old_byte = 8'h00;
	logic                 tx_load = 1'b0;
	logic [7:0]           tx_data = 8'h00;
	logic                 sck, cs_n, mosi, hold_n, miso_o, miso_oe_n;
	logic                 active, standby, protect_lock, fast_mode, discard;
	sfs_pkg::sfs_rx_t     rx;
	sfs_pkg::sfs_prog_t   prog;
	sfs_pkg::sfs_commit_t commit;
	logic [39:0]          notes[$];
	logic [31:0]          seed = 32'hde87;
	logic [23:0]          addr;
	logic [7:0]           d;
	logic [7:0]           cap = 8'h00;
	int                   err_count = 0;
	int                   compares = 0;

	always #2.5 mclk = ~mclk;

	sfs_master #(.START_SEL(1'b1)) m (.sck, .cs_n, .mosi, .hold_n, .mode);
	sfs_front #(.OP_PROG(8'h01), .OP_SECTOR(8'h02), .OP_BULK(8'h03), .OP_STATUS(8'h04)) dut (
		.mclk, .rstn, .sck, .cs_n, .mosi, .hold_n, .wp_n,
		.high_program_voltage_level(hv), .busy, .old_byte, .tx_load, .tx_data,
		.miso_o, .miso_oe_n, .active, .standby, .protect_lock, .fast_mode,
		.rx, .prog, .commit, .discard
	);

	task automatic chk(input string what, input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic take(input string what, input logic [39:0] got);
		if (notes.size() == 0)
			chk(what, got, {40{1'bz}});
		else
			chk(what, got, notes.pop_front());
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic send(input logic [7:0] b, input logic f, input int hb);
		notes.push_back({2'd0, 29'd0, f, b});
		m.xfer(b, 8, hb);
	endtask
	task automatic prog_note(input int i);
		notes.push_back({2'd1, 7'd0, addr[22:16], addr[15:8], addr[7:0] + 8'(i), old_byte & d});
	endtask

	always @(negedge mclk) begin
		if (prog.valid) take("prog", {2'd1, 7'd0, prog.sector, prog.page, prog.col, prog.data});
		if (rx.valid) take("rx", {2'd0, 29'd0, rx.first, rx.data});
		if (commit.valid) take("commit", {2'd2, 25'd0, commit.kind, commit.fast,
			(commit.kind == sfs_pkg::CMD_PROG) ? commit.count : 9'd0});
		if (discard) take("discard", {2'd3, 38'd0});
	end
	always @(posedge sck) cap <= {cap[6:0], miso_o};
	always @(cs_n or hold_n) begin
		#1 chk("oe_n", {39'd0, miso_oe_n}, {39'd0, cs_n | ~hold_n});
	end

	initial begin
		repeat (4) @(negedge mclk);
		rstn = 1'b1;
		repeat (4) @(negedge mclk);
		m.xfer(8'h01, 8, 9);
		m.desel();
		$display("test preselect done");
		addr = 24'($random(seed));
		addr[7:0] = 8'hff;
		old_byte = 8'($random(seed));
		m.sel();
		send(8'h01, 1'b1, 9);
		chk("active", {38'd0, active, standby}, 40'h2);
		tx_data = 8'($random(seed));
		@(negedge mclk) tx_load = 1'b1;
		@(negedge mclk) tx_load = 1'b0;
		send(addr[23:16], 1'b0, 9);
		chk("miso", {32'd0, cap}, {32'd0, tx_data});
		for (int i = 1; i >= 0; i--) send(addr[8*i +: 8], 1'b0, 9);
		for (int i = 0; i < 2; i++) begin
			d = 8'($random(seed));
			prog_note(i);
			send(d, 1'b0, 3 - i);
		end
		notes.push_back({2'd2, 25'd0, sfs_pkg::CMD_PROG, 1'b0, 9'd2});
		m.desel();
		$display("test program done");
		mode = 1'b1;
		for (int k = 0; k < 3; k++) begin
			hv = (k == 0);
			wp_n = k[0];
			addr = 24'($random(seed));
			repeat (16) @(negedge mclk);
			chk("fast", {39'd0, fast_mode}, {39'd0, hv});
			chk("lock", {39'd0, protect_lock}, {39'd0, ~wp_n & ~hv});
			m.sel();
			send(8'(2 + k), 1'b1, 9);
			if (k == 0)
				for (int i = 2; i >= 0; i--) send(addr[8*i +: 8], 1'b0, 9);
			if (k == 2)
				send(addr[7:0], 1'b0, 9);
			notes.push_back({2'd2, 25'd0, sfs_pkg::sfs_cmd_t'(3'(k + 2)), hv, 9'd0});
			m.desel();
		end
		hv = 1'b0;
		$display("test erase done");
		m.sel();
		send(8'h01, 1'b1, 9);
		for (int i = 2; i >= 0; i--) send(addr[8*i +: 8], 1'b0, 9);
		d = 8'($random(seed));
		prog_note(0);
		send(d, 1'b0, 9);
		m.xfer(8'h5a, 3, 9);
		notes.push_back({2'd3, 38'd0});
		m.desel();
		$display("test partial done");
		busy = 1'b1;
		repeat (16) @(negedge mclk);
		chk("busy", {38'd0, active, standby}, 40'h2);
		busy = 1'b0;
		repeat (16) @(negedge mclk);
		chk("idle", {38'd0, active, standby}, 40'h1);
		$display("test power done");
		repeat (20) @(negedge mclk);
		chk("drained", 40'(notes.size()), 40'h0);
		print_verdict();
	end
	initial begin
		#100000;
		err_count++;
		print_verdict();
	end
endmodule
